// File: design/rds_defs.svh
// constants for the radio data block synchroniser and group decoder
`ifndef RDS_DEFS_SVH
`define RDS_DEFS_SVH
`define RDS_BLOCK_BITS 5'd26
`define RDS_SYNDROME_A 10'h3d8
`define RDS_SYNDROME_B 10'h3d4
`define RDS_SYNDROME_C 10'h25c
`define RDS_SYNDROME_CP 10'h3cc
`define RDS_SYNDROME_D 10'h158
`define RDS_TRUST_LOAD 8'd42
`define RDS_TRUST_STEP 8'd4
`define RDS_TRUST_SYNC 8'd41
`define RDS_TRUST_BAD 8'd10
`define RDS_TRUST_CAP 8'd56
`define RDS_EON_MAX 4'd11
`define RDS_EON_AF_CODE 4'd4
`define RDS_NODATA_MS 10000
`define RDS_CLK_KHZ 100000
`define RDS_REG_CTRL 12'h000
`define RDS_REG_STATUS 12'h004
`define RDS_REG_PI 12'h008
`define RDS_REG_FLAGS 12'h00c
`define RDS_REG_PIN 12'h010
`define RDS_REG_TIME 12'h014
`define RDS_REG_OFS 12'h018
`define RDS_REG_GRP_LO 12'h01c
`define RDS_REG_GRP_HI 12'h020
`define RDS_REG_SYNDROME 12'h024
`define RDS_REG_PS 12'h040
`define RDS_REG_RT 12'h080
`define RDS_REG_EON 12'h100
`define RDS_CTRL_HALT 0
`define RDS_CTRL_CLR 1
`endif

// File: design/rds_pkg.sv
// types of the radio data block synchroniser and group decoder
package rds_pkg;
  typedef enum logic [3:0] {
    grp_basic = 4'b0000,
    grp_pin = 4'b0001,
    grp_text = 4'b0010,
    grp_clock = 4'b0100,
    grp_other_net = 4'b1110,
    grp_fast_switch = 4'b1111
  } group_kind_e;

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic dat_s1;
    logic dat_s2;
    logic halt;
    logic [31:0] shift;
    logic [4:0] bit_cnt;
    logic synced;
    logic [1:0] block_position;
    logic [7:0] sync_confidence;
    logic [9:0] syndrome_word;
    logic [63:0] group_staging_buffer;
    logic [63:0] group_buf;
    logic group_ready;
    logic [31:0] idle_cnt;
    logic [31:0] prdata;
    logic [15:0] pi;
    logic [4:0] pty;
    logic tp;
    logic ta;
    logic ms;
    logic [3:0] di;
    logic text_ab;
    logic text_seen;
    logic [7:0][7:0] ps;
    logic [15:0] pin;
    logic [63:0][7:0] rt;
    logic [16:0] mjd;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] ofs;
    logic [3:0] eon_cnt;
    logic [10:0][15:0] eon_pi;
    logic [10:0][7:0] eon_freq;
    logic [10:0][7:0][7:0] eon_ps;
  } state_s;
endpackage

// File: design/rds_block_sync_group_decoder.sv
// radio data block synchroniser, confidence tracker and group decoder with apb registers
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "rds_defs.svh"
module rds_block_sync_group_decoder
  import rds_pkg::*;
#(
  parameter int unsigned NODATA_CYCLES = `RDS_NODATA_MS * `RDS_CLK_KHZ
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // demodulator link
  input wire logic rds_clk,
  input wire logic rds_data,
  // status and group output
  output logic synced,
  output logic signal_unusable,
  output logic group_ready,
  output logic [63:0] group_data
);
  localparam logic [11:0] PS_BASE = `RDS_REG_PS;
  localparam logic [11:0] RT_BASE = `RDS_REG_RT;
  localparam logic [11:0] EON_BASE = `RDS_REG_EON;
  // rows 10 to 25 of the check matrix, row 10 at the top index
  localparam logic [15:0][9:0] CHECK_ROWS = {
    10'h2dc, 10'h16e, 10'h0b7, 10'h287, 10'h39f, 10'h313, 10'h355, 10'h376,
    10'h1bb, 10'h201, 10'h3dc, 10'h1ee, 10'h0f7, 10'h2a7, 10'h38f, 10'h31b};

  state_s q;
  state_s d;
  logic edge_seen;
  logic check;
  logic valid;
  logic timeout_hit;
  logic [9:0] syndrome;
  logic [15:0] b1;
  logic [15:0] b2;
  logic [15:0] b3;
  logic [15:0] b4;

  function automatic logic [9:0] syndrome_of(input logic [25:0] win);
    logic [9:0] s;
    s = win[25:16];
    for (int i = 0; i < 16; i++)
    begin
      if (win[i])
      begin
        s = s ^ CHECK_ROWS[i];
      end
    end
    return s;
  endfunction

  function automatic logic reg_hit(input logic [11:0] a);
    return (a[1:0] == 2'b00) &&
      ((a <= `RDS_REG_SYNDROME) || (a[11:3] == PS_BASE[11:3]) || (a[11:6] == RT_BASE[11:6]) ||
       ((a[11:8] == EON_BASE[11:8]) && (a[7:4] < `RDS_EON_MAX)));
  endfunction

  function automatic logic [31:0] reg_read(input state_s s, input logic [11:0] a);
    logic [31:0] r;
    logic [3:0] n;
    r = '0;
    n = a[7:4];
    if (a[11:3] == PS_BASE[11:3])
      r = s.ps[{a[2], 2'b00} +: 4];
    else if (a[11:6] == RT_BASE[11:6])
      r = s.rt[{a[5:2], 2'b00} +: 4];
    else if ((a[11:8] == EON_BASE[11:8]) && (n < `RDS_EON_MAX))
    begin
      case (a[3:2])
        2'd0: r = {16'h0000, s.eon_pi[n]};
        2'd1: r = {24'h000000, s.eon_freq[n]};
        2'd2: r = s.eon_ps[n][3:0];
        default: r = s.eon_ps[n][7:4];
      endcase
    end
    else
    begin
      case (a)
        `RDS_REG_CTRL: r = {31'h0, s.halt};
        `RDS_REG_STATUS: r = {8'h00, s.eon_cnt, 3'b000, s.text_ab, s.sync_confidence, 4'h0,
                              s.block_position, s.sync_confidence < `RDS_TRUST_BAD, s.synced};
        `RDS_REG_PI: r = {16'h0000, s.pi};
        `RDS_REG_FLAGS: r = {20'h00000, s.di, s.ms, s.ta, s.tp, s.pty};
        `RDS_REG_PIN: r = {s.pin[5:0], s.pin[10:6], s.pin[15:11], s.pin};
        `RDS_REG_TIME: r = {4'h0, s.minute, s.hour, s.mjd};
        `RDS_REG_OFS: r = {{26{s.ofs[5]}}, s.ofs};
        `RDS_REG_GRP_LO: r = s.group_buf[63:32];
        `RDS_REG_GRP_HI: r = s.group_buf[31:0];
        `RDS_REG_SYNDROME: r = {22'h000000, s.syndrome_word};
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  assign b1 = q.group_buf[63:48];
  assign b2 = q.group_buf[47:32];
  assign b3 = q.group_buf[31:16];
  assign b4 = q.group_buf[15:0];

  always_comb
  begin
    logic [4:0] cnt_nxt;
    logic [15:0] info;
    logic soft_clr;
    logic wipe;
    logic hit;
    logic [3:0] slot;
    cnt_nxt = '0;
    info = '0;
    soft_clr = 1'b0;
    wipe = 1'b0;
    hit = 1'b0;
    slot = '0;
    check = 1'b0;
    valid = 1'b0;
    d = q;
    d.group_ready = 1'b0;
    // link synchronisers; the edge detector looks only at the second and third stages
    d.clk_s1 = rds_clk;
    d.clk_s2 = q.clk_s1;
    d.clk_s3 = q.clk_s2;
    d.dat_s1 = rds_data;
    d.dat_s2 = q.dat_s1;
    edge_seen = q.clk_s2 && !q.clk_s3 && !q.halt;
    // blocks arrive back to back, so the counter never needs a resync gap
    if (edge_seen)
    begin
      d.shift = {q.shift[30:0], q.dat_s2};
      cnt_nxt = q.bit_cnt + 5'd1;
      check = !q.synced || (cnt_nxt == `RDS_BLOCK_BITS);
      d.bit_cnt = check ? 5'd0 : cnt_nxt;
    end
    syndrome = syndrome_of(d.shift[25:0]);
    if (check)
    begin
      d.syndrome_word = syndrome;
      case (q.block_position)
        2'd0: valid = (syndrome == `RDS_SYNDROME_A);
        2'd1: valid = (syndrome == `RDS_SYNDROME_B);
        2'd2: valid = (syndrome == `RDS_SYNDROME_C) || (syndrome == `RDS_SYNDROME_CP);
        default: valid = (syndrome == `RDS_SYNDROME_D);
      endcase
      if (valid)
      begin
        info = d.shift[25:10];
        d.group_staging_buffer[{~q.block_position, 4'h0} +: 16] = info;
        d.block_position = q.block_position + 2'd1;
        if (!q.synced)
        begin
          d.synced = 1'b1;
          d.sync_confidence = `RDS_TRUST_LOAD;
        end
        else if (q.sync_confidence <= `RDS_TRUST_CAP)
          d.sync_confidence = q.sync_confidence + `RDS_TRUST_STEP;
        if (q.block_position == 2'd3)
        begin
          d.group_buf = {q.group_staging_buffer[63:16], info};
          d.group_ready = 1'b1;
        end
      end
      else
      begin
        d.block_position = 2'd0;
        // saturate so the long search cannot wrap the counter
        if (q.sync_confidence != 8'd0)
          d.sync_confidence = q.sync_confidence - 8'd1;
        if (d.sync_confidence < `RDS_TRUST_SYNC)
          d.synced = 1'b0;
      end
    end
    // silence timer restarts on any valid syndrome
    timeout_hit = !valid && (q.idle_cnt == NODATA_CYCLES - 1);
    if (valid || timeout_hit)
      d.idle_cnt = '0;
    else
      d.idle_cnt = q.idle_cnt + 32'd1;
    // apb: zero wait states, read data captured in the setup cycle
    if (psel && penable && pwrite && (paddr == `RDS_REG_CTRL))
    begin
      d.halt = pwdata[`RDS_CTRL_HALT];
      soft_clr = pwdata[`RDS_CTRL_CLR];
    end
    if (psel && !penable)
      d.prdata = reg_read(q, paddr);
    // programme data wipe; date and time survive every cause
    wipe = soft_clr || timeout_hit ||
      (q.group_ready && (b1 != q.pi)) ||
      ((d.sync_confidence < `RDS_TRUST_BAD) && (q.sync_confidence >= `RDS_TRUST_BAD));
    if (wipe)
    begin
      d.pi = '0;
      d.pty = '0;
      d.tp = 1'b0;
      d.ta = 1'b0;
      d.ms = 1'b0;
      d.di = '0;
      d.text_ab = 1'b0;
      d.text_seen = 1'b0;
      d.ps = '0;
      d.pin = '0;
      d.rt = '0;
      d.eon_cnt = '0;
      d.eon_pi = '0;
      d.eon_freq = '0;
      d.eon_ps = '0;
    end
    // group decode runs the cycle after the output buffer is loaded
    if (q.group_ready)
    begin
      d.pi = b1;
      d.pty = b2[9:5];
      d.tp = b2[10];
      case (group_kind_e'(b2[15:12]))
        grp_basic:
        begin
          d.ps[{b2[1:0], 1'b0}] = b4[15:8];
          d.ps[{b2[1:0], 1'b1}] = b4[7:0];
          d.ta = b2[4];
          d.ms = b2[3];
          d.di[~b2[1:0]] = b2[2];
        end
        grp_fast_switch:
        begin
          if (b2[11])
          begin
            d.ta = b2[4];
            d.ms = b2[3];
            d.di[~b2[1:0]] = b2[2];
          end
        end
        grp_pin:
          d.pin = b4;
        grp_text:
        begin
          // version B text is ignored
          if (!b2[11])
          begin
            if (d.text_seen && (b2[4] != q.text_ab))
              d.rt = '0;
            d.text_ab = b2[4];
            d.text_seen = 1'b1;
            d.rt[{b2[3:0], 2'd0}] = b3[15:8];
            d.rt[{b2[3:0], 2'd1}] = b3[7:0];
            d.rt[{b2[3:0], 2'd2}] = b4[15:8];
            d.rt[{b2[3:0], 2'd3}] = b4[7:0];
          end
        end
        grp_clock:
        begin
          if (!b2[11])
          begin
            d.mjd = {b2[1:0], b3[15:1]};
            d.hour = {b3[0], b4[15:12]};
            d.minute = b4[11:6];
            // sign and magnitude in half hours become two's complement
            d.ofs = b4[5] ? 6'd0 - {1'b0, b4[4:0]} : {1'b0, b4[4:0]};
          end
        end
        grp_other_net:
        begin
          if (!b2[11])
          begin
            for (int i = 0; i < 11; i++)
            begin
              if (!hit && (4'(i) < d.eon_cnt) && (d.eon_pi[i] == b4))
              begin
                hit = 1'b1;
                slot = 4'(i);
              end
            end
            // table full: further networks are dropped, known ones still update
            if (hit || (d.eon_cnt < `RDS_EON_MAX))
            begin
              if (!hit)
              begin
                slot = d.eon_cnt;
                d.eon_cnt = d.eon_cnt + 4'd1;
                d.eon_pi[slot] = b4;
              end
              if (b2[3:0] < `RDS_EON_AF_CODE)
              begin
                d.eon_ps[slot][{b2[1:0], 1'b0}] = b3[15:8];
                d.eon_ps[slot][{b2[1:0], 1'b1}] = b3[7:0];
              end
              else if (b2[3:0] == `RDS_EON_AF_CODE)
                d.eon_freq[slot] = b3[15:8];
            end
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);
  assign synced = q.synced;
  assign signal_unusable = q.sync_confidence < `RDS_TRUST_BAD;
  assign group_ready = q.group_ready;
  assign group_data = q.group_buf;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  shift_in_a: assert property (
    edge_seen |=> (q.shift[0] == $past(q.dat_s2)) && (q.shift[31:1] == $past(q.shift[30:0])))
    else $error("received bit not shifted in");
  search_check_a: assert property (
    edge_seen && !q.synced |-> check)
    else $error("search mode skipped a syndrome check");
  block_check_a: assert property (
    check && q.synced |-> q.bit_cnt == 5'd25)
    else $error("locked check not on 26th bit");
  pos_zero_a: assert property (
    valid && (q.block_position == 2'd0) |-> syndrome == `RDS_SYNDROME_A)
    else $error("position zero accepted other than A");
  miss_drop_a: assert property (
    check && !valid && (q.sync_confidence != 8'd0) |=>
      (q.block_position == 2'd0) && (q.sync_confidence == $past(q.sync_confidence) - 8'd1))
    else $error("miss did not clear position and lower confidence");
  first_lock_a: assert property (
    valid && !q.synced |=> q.synced && (q.sync_confidence == `RDS_TRUST_LOAD))
    else $error("first lock did not load confidence");
  trust_step_a: assert property (
    valid && q.synced && (q.sync_confidence <= `RDS_TRUST_CAP) |=>
      q.sync_confidence == $past(q.sync_confidence) + `RDS_TRUST_STEP)
    else $error("valid block did not add four");
  trust_cap_a: assert property (
    valid && q.synced && (q.sync_confidence > `RDS_TRUST_CAP) |=> $stable(q.sync_confidence))
    else $error("confidence raised above cap");
  lock_floor_a: assert property (
    q.synced |-> q.sync_confidence >= `RDS_TRUST_SYNC)
    else $error("locked with low confidence");
  group_copy_a: assert property (
    valid && (q.block_position == 2'd3) |=>
      q.group_ready && (q.group_buf[63:16] == $past(q.group_staging_buffer[63:16])))
    else $error("group not copied on block D");
  ready_pulse_a: assert property (
    q.group_ready |=> !q.group_ready)
    else $error("group ready longer than one cycle");
endmodule

// File: verif/demod_model.sv
// behavioural fm demodulator: radio data bit clock and data line
`timescale 1ns/1ps
module demod_model
(
  // link outputs
  output logic rds_clk,
  output logic rds_data
);
  initial
  begin
    rds_clk = 1'b0;
    rds_data = 1'b0;
  end

  // one bit per 125 ns, data set 60 ns before the rising edge and held 65 ns after it;
  // the clock stands still between calls, so blocks must follow back to back
  // every change lands on a half nanosecond, clear of the system clock edges
  task automatic send_bit(input logic b);
    #2.5 rds_data = b;
    #60 rds_clk = 1'b1;
    #60 rds_clk = 1'b0;
    #2.5;
  endtask

  // end of a frame: a released line must not keep showing the last bit
  task automatic release_line();
    #2.5 rds_data = ~rds_data;
  endtask
endmodule

// File: verif/tb_top.sv
// self-checking bench for the radio data block synchroniser and group decoder
`timescale 1ns/1ps
`include "rds_defs.svh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rds_clk, rds_data;
  logic synced, signal_unusable, group_ready, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, t_exp;
  logic [63:0] group_data, g;
  logic [15:0] lfsr_q = 16'h336c, pi, d3, d4, pi_m, stg [4];
  logic [25:0] win;
  logic [63:0] q_grp [$];
  int err_total, comparisons, trust, pos, cnt;
  bit sync_m, halt_m;
  localparam logic [9:0] hrow [26] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h010, 10'h008,
    10'h004, 10'h002, 10'h001, 10'h2dc, 10'h16e, 10'h0b7, 10'h287, 10'h39f, 10'h313, 10'h355,
    10'h376, 10'h1bb, 10'h201, 10'h3dc, 10'h1ee, 10'h0f7, 10'h2a7, 10'h38f, 10'h31b};

  rds_block_sync_group_decoder #(.NODATA_CYCLES(20000)) rds_block_sync_group_decoder_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rds_clk(rds_clk), .rds_data(rds_data),
    .synced(synced), .signal_unusable(signal_unusable), .group_ready(group_ready), .group_data(group_data));
  demod_model demod_model_inst (.rds_clk(rds_clk), .rds_data(rds_data));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic fail(input string m);
    err_total++;
    $display("mismatch %0t %s", $time, m);
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  // xor of matrix rows, first received bit on the top row
  function automatic logic [9:0] calc_syndrome(input logic [25:0] w);
    logic [9:0] s = 10'h0;
    for (int i = 0; i < 26; i++)
      if (w[25 - i])
        s ^= hrow[i];
    return s;
  endfunction

  // 16 information bits then the 10 check bits giving syndrome t
  function automatic logic [25:0] mk(input logic [15:0] d, input logic [9:0] t);
    for (int c = 0; c < 1024; c++)
      if (calc_syndrome({d, c[9:0]}) == t)
        return {d, c[9:0]};
    return 26'h0;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 50)
    begin
      fail("apb hang");
      tally_and_finish;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    comparisons++;
    if (rd !== e || er !== 1'b0)
      fail($sformatf("read %h got %h want %h", a, rd, e));
  endtask

  task automatic dec;
    if (trust > 0)
    begin
      trust--;
      if (trust == 9)
        pi_m = 16'h0;
    end
    if (trust < 41)
      sync_m = 0;
  endtask

  // reference model of the search, lock and confidence tracking, one call per bit
  task automatic bit_tx(input logic b);
    logic [9:0] s;
    bit ok;
    if (!halt_m)
    begin
      win = {win[24:0], b};
      s = calc_syndrome(win);
      if (!sync_m)
      begin
        if (s == `RDS_SYNDROME_A)
        begin
          sync_m = 1;
          trust = 42;
          pos = 1;
          cnt = 0;
          stg[0] = win[25:10];
        end
        else
          dec;
      end
      else if (++cnt == 26)
      begin
        cnt = 0;
        ok = (pos == 0) ? s == `RDS_SYNDROME_A : (pos == 1) ? s == `RDS_SYNDROME_B :
          (pos == 3) ? s == `RDS_SYNDROME_D : s == (stg[1][11] ? `RDS_SYNDROME_CP : `RDS_SYNDROME_C);
        if (ok)
        begin
          if (trust <= 56)
            trust += 4;
          stg[pos] = win[25:10];
          if (pos == 3)
          begin
            q_grp.push_back({stg[0], stg[1], stg[2], stg[3]});
            pi_m = stg[0];
          end
          pos = (pos + 1) % 4;
        end
        else
        begin
          pos = 0;
          dec;
        end
      end
    end
    demod_model_inst.send_bit(b);
  endtask

  task automatic settle;
    demod_model_inst.release_line();
    repeat (4) @(posedge pclk);
    comparisons++;
    if (synced !== sync_m)
      fail("lock state");
    apb(1'b0, `RDS_REG_STATUS, 32'h0);
    comparisons++;
    if (rd[15:0] !== {trust[7:0], 4'h0, pos[1:0], trust < 10, sync_m})
      fail($sformatf("status %h", rd));
    comparisons++;
    if (signal_unusable !== (trust < 10))
      fail("unusable pin");
  endtask

  task automatic send_grp(input logic [15:0] b1, b2, b3, b4);
    logic [25:0] w [4];
    w = '{mk(b1, `RDS_SYNDROME_A), mk(b2, `RDS_SYNDROME_B), mk(b3, b2[11] ? `RDS_SYNDROME_CP : `RDS_SYNDROME_C),
      mk(b4, `RDS_SYNDROME_D)};
    foreach (w[k])
      for (int i = 25; i >= 0; i--)
        bit_tx(w[k][i]);
    settle;
  endtask

  always @(posedge pclk)
    if (group_ready === 1'b1)
    begin
      comparisons++;
      if (q_grp.size() == 0)
        fail("unexpected group pulse");
      else
      begin
        g = q_grp.pop_front();
        if (group_data !== g)
          fail("group data");
      end
    end

  initial
  begin
    repeat (90000) @(posedge pclk);
    fail("timeout");
    tally_and_finish;
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    win = 26'h0;
    pi_m = 16'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    comparisons++;
    if (group_data !== 64'h0 || group_ready !== 1'b0)
      fail("reset outputs");
    apb(1'b0, 12'h1fc, 32'h0);
    comparisons++;
    if (er !== 1'b1 || rd !== 32'h0)
      fail("unmapped read");
    apb(1'b1, `RDS_REG_PI, 32'hffffffff);
    chk(`RDS_REG_PI, 32'h0);
    pi = rnd();
    d4 = rnd();
    send_grp(pi, 16'h057d, rnd(), d4);
    chk(`RDS_REG_PI, {16'h0, pi});
    chk(`RDS_REG_FLAGS, 32'h000004eb);
    chk(`RDS_REG_PS, {d4[7:0], d4[15:8], 16'h0});
    send_grp(pi, 16'hf867, pi, 16'hf867);
    chk(`RDS_REG_FLAGS, 32'h00000503);
    chk(`RDS_REG_PS + 12'h4, 32'h0);
    d3 = rnd();
    d4 = rnd();
    send_grp(pi, 16'h2422, d3, d4);
    chk(`RDS_REG_RT + 12'h8, {d4[7:0], d4[15:8], d3[7:0], d3[15:8]});
    send_grp(pi, 16'h2c32, pi, rnd());
    chk(`RDS_REG_RT + 12'h8, {d4[7:0], d4[15:8], d3[7:0], d3[15:8]});
    d3 = rnd();
    d4 = rnd();
    send_grp(pi, 16'h2433, d3, d4);
    chk(`RDS_REG_RT + 12'h8, 32'h0);
    chk(`RDS_REG_RT + 12'hc, {d4[7:0], d4[15:8], d3[7:0], d3[15:8]});
    d4 = rnd();
    send_grp(pi, 16'h1000, rnd(), d4);
    chk(`RDS_REG_PIN, {d4[5:0], d4[10:6], d4[15:11], d4});
    d3 = rnd();
    d4 = rnd();
    send_grp(pi, 16'h4401, d3, d4);
    t_exp = {4'h0, d4[11:6], d3[0], d4[15:12], 2'b01, d3[15:1]};
    chk(`RDS_REG_TIME, t_exp);
    chk(`RDS_REG_OFS, d4[5] ? -int'(d4[4:0]) : int'(d4[4:0]));
    d3 = rnd();
    d4 = rnd();
    send_grp(pi, 16'he400, d3, d4);
    chk(`RDS_REG_EON, {16'h0, d4});
    chk(`RDS_REG_EON + 12'h8, {16'h0, d3[7:0], d3[15:8]});
    d3 = rnd();
    send_grp(pi, 16'he404, d3, d4);
    chk(`RDS_REG_EON + 12'h4, {24'h0, d3[15:8]});
    // noise: lock loss, then the confidence runs down through the unusable level
    repeat (520)
    begin
      d3 = rnd();
      bit_tx(d3[0]);
    end
    settle;
    chk(`RDS_REG_PI, {16'h0, pi_m});
    apb(1'b1, `RDS_REG_CTRL, 32'h1);
    halt_m = 1;
    send_grp(pi, 16'h057d, rnd(), rnd());
    apb(1'b1, `RDS_REG_CTRL, 32'h0);
    halt_m = 0;
    send_grp(pi, 16'h057d, rnd(), rnd());
    chk(`RDS_REG_PI, {16'h0, pi_m});
    apb(1'b1, `RDS_REG_CTRL, 32'h2);
    pi_m = 16'h0;
    chk(`RDS_REG_PI, 32'h0);
    pi = rnd();
    send_grp(pi, 16'h057d, rnd(), rnd());
    repeat (19000) @(posedge pclk);
    chk(`RDS_REG_PI, {16'h0, pi_m});
    repeat (1500) @(posedge pclk);
    chk(`RDS_REG_PI, 32'h0);
    chk(`RDS_REG_TIME, t_exp);
    comparisons++;
    if (q_grp.size() != 0)
      fail("missing group");
    tally_and_finish;
  end
endmodule
